/* File: src/timer_clock_pkg.sv */
// constants, register map and carriers for the timer clock and counter block
package timer_clock_pkg;
  // register byte addresses
  localparam logic [7:0] A_RUN = 8'h88;
  localparam logic [7:0] A_MODE = 8'h89;
  localparam logic [7:0] A_T0LO = 8'h8a;
  localparam logic [7:0] A_T1LO = 8'h8b;
  localparam logic [7:0] A_T0HI = 8'h8c;
  localparam logic [7:0] A_T1HI = 8'h8d;
  localparam logic [7:0] A_TIMER_CLOCK_CONTROL = 8'h8e;
  localparam logic [7:0] A_IRQEN = 8'ha8;
  localparam logic [7:0] A_T2BASE = 8'hc8;
  localparam logic [7:0] A_T3BASE = 8'hd8;
  // offsets inside a timer 2/3 window
  localparam logic [7:0] O_CTL = 8'h00;
  localparam logic [7:0] O_RLL = 8'h02;
  localparam logic [7:0] O_RLH = 8'h03;
  localparam logic [7:0] O_CNL = 8'h04;
  localparam logic [7:0] O_CNH = 8'h05;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timer_clock_control fields
  localparam int CK_PRE = 0;
  localparam int CK_T0_SEL = 2;
  localparam int CK_T23 = 4;
  // run_control_reg fields, timer 1 sits two bits above timer 0
  localparam int RC_TR0 = 4;
  localparam int RC_TF0 = 5;
  // mode_select_reg fields, timer 1 sits four bits above timer 0
  localparam int MS_STRIDE = 4;
  localparam int MS_CS = 2;
  localparam int MS_GATE = 3;
  // interrupt_enable_reg fields
  localparam int IE_T0 = 1;
  localparam int IE_T1 = 3;
  localparam int IE_T2 = 5;
  localparam int IE_T3 = 7;
  // timer 2/3 control fields
  localparam int X_SEL = 0;
  localparam int X_RUN = 2;
  localparam int X_CAP = 4;
  localparam int X_SPLIT = 5;
  localparam int X_LOF = 6;
  localparam int X_HIF = 7;
  // prescaler codes and divider terminal counts
  localparam logic [1:0] PRE_DIV12 = 2'b00;
  localparam logic [1:0] PRE_DIV4 = 2'b01;
  localparam logic [1:0] PRE_DIV48 = 2'b10;
  localparam logic [1:0] PRE_EXT8 = 2'b11;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV48_LAST = 2'h3;
  localparam logic [2:0] SRC8_LAST = 3'h7;
  // alternate clock choices for timer 2/3
  localparam logic [1:0] ALT_DIV12 = 2'b00;
  localparam logic [1:0] ALT_SRC8 = 2'b01;
  localparam logic [1:0] ALT_CMP = 2'b10;
  // timer 0/1 modes
  localparam logic [1:0] M_13BIT = 2'b00;
  localparam logic [1:0] M_16BIT = 2'b01;
  localparam logic [1:0] M_RELOAD = 2'b10;
  localparam logic [1:0] M_SPLIT = 2'b11;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [1:0] cmp;
    logic rtc;
    logic ext;
    logic [1:0] gate;
    logic [1:0] event_in;
  } pins_s;
endpackage

/* File: src/timer_clock_prescaler.sv */
// clock selection, prescaling and counters for four timers
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) clock select bits 2 and 3: zero prescaled clock, one system clock
// (RULE2) clock select ignored while that timer counts external events
// (RULE3) prescale codes 00, 01, 10 divide system clock by 12, 4, 48
// (RULE4) prescale code 11 uses external clock divided by 8, synchronised first
// (RULE5) counter mode increments once per falling edge on the event pin
// (RULE6) events up to a quarter of system clock, aperiodic, are counted
// (RULE7) the source holds each event level at least two system clocks
// (RULE8) bit 4 picks timer 2 low or whole clock: alternate or system clock
// (RULE9) bit 5 picks timer 2 high byte clock, split mode only
// (RULE10) bit 6 picks timer 3 low or whole clock: alternate or system clock
// (RULE11) bit 7 picks timer 3 high byte clock, split mode only
// (RULE12) timer 2 runs from system, system/12, rtc/8 or comparator 0
// (RULE13) timer 3 runs from system, system/12, ext oscillator/8 or comparator 1
// (RULE14) timers 0 and 1 hold sixteen bits read and written as two bytes
// (RULE15) run control enables timers 0/1 and flags them; enables gate interrupts
// (RULE16) mode register selects one of four modes per timer independently
// (RULE17) modes: 13-bit, 16-bit, 8-bit reload, split pair for timer 0 only
// (RULE18) timers 2/3 run as 16-bit reload or two 8-bit reload timers
// (RULE19) timers 2/3 capture the period of rtc or comparator signal
// (RULE20) counter select one counts pin falling edges, else selected clock
// (RULE21) every timebase reaches the counters as a one-cycle enable
module timer_clock_prescaler
  import timer_clock_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire reg_req_s req,
  output logic [7:0] rd_data,
  // asynchronous pins
  input wire pins_s pins,
  // interrupt requests, one per timer
  output logic [3:0] irq
);

  // software-owned control registers
  logic [7:0] timer_clock_control;
  logic [7:0] run_control_reg;
  logic [7:0] mode_select_reg;
  logic [7:0] ien;

  // pin synchroniser stages
  pins_s s1, s2, s3;
  logic [1:0] ev_fall;
  logic [1:0] src_rise;
  logic [1:0] src8_tick;
  logic [1:0] cmp_rise;

  // free-running system clock dividers
  logic [3:0] div12_cnt;
  logic [1:0] div4_cnt;
  logic [1:0] div48_cnt;
  logic div12_tick, div4_tick, div48_tick, pre_tick;

  // timer 0/1 flag plumbing and registered outputs
  logic t0_split;
  logic [1:0] tf_set;
  logic [3:0] next_irq;
  logic [7:0] next_rd;

  // decode a register inside a timer 2/3 window
  // used by both the write decode and the read mux, hence a function
  function automatic logic hit23(input logic [7:0] a, input int j, input logic [7:0] off);
    logic [7:0] base;
    base = (j == 0) ? A_T2BASE : A_T3BASE;
    hit23 = (a == base + off);
  endfunction

  // two-stage synchronisers; third stage only feeds edge detection
  // the pins are asynchronous, so logic reads only s2 and s3;
  // a pin that moves near an edge may cost one cycle of latency
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign ev_fall = s3.event_in & ~s2.event_in; // RULE5 RULE6
  assign src_rise = {s2.rtc & ~s3.rtc, s2.ext & ~s3.ext};
  assign cmp_rise = s2.cmp & ~s3.cmp;

  // divide synced ext and rtc by eight; inputs must stay under half clk rate
  // the divided clocks never drive a clock pin: each eighth synchronised
  // rising edge becomes a one-cycle enable instead
  for (genvar k = 0; k < 2; k++) begin : g_src8
    logic [2:0] cnt;
    always_ff @(posedge clk) begin
      if (!resetn) begin
        cnt <= '0;
      end else if (src_rise[k]) begin
        cnt <= cnt + 3'h1;
      end
    end
    assign src8_tick[k] = src_rise[k] && cnt == SRC8_LAST; // RULE4 RULE21
  end

  // system clock dividers; div48 is every fourth div12 tick
  // a new prescale choice takes effect at its next tick; the divider phase
  // is not restarted, so the first prescaled period may be short
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div12_cnt <= '0;
      div4_cnt <= '0;
      div48_cnt <= '0;
    end else begin
      div4_cnt <= div4_cnt + 2'h1;
      div12_cnt <= div12_tick ? 4'h0 : div12_cnt + 4'h1;
      if (div12_tick) begin
        div48_cnt <= div48_cnt + 2'h1;
      end
    end
  end

  assign div12_tick = div12_cnt == DIV12_LAST;
  assign div4_tick = div4_cnt == DIV4_LAST;
  assign div48_tick = div12_tick && div48_cnt == DIV48_LAST;

  // shared timer 0/1 prescaled enable
  always_comb begin
    case (timer_clock_control[CK_PRE+:2]) // RULE3 RULE4
      PRE_DIV12: pre_tick = div12_tick;
      PRE_DIV4: pre_tick = div4_tick;
      PRE_DIV48: pre_tick = div48_tick;
      PRE_EXT8: pre_tick = src8_tick[0];
      default: pre_tick = div12_tick;
    endcase
  end

  assign t0_split = mode_select_reg[1:0] == M_SPLIT;

  // timers 0 and 1
  for (genvar i = 0; i < 2; i++) begin : g_t01
    logic [7:0] lo, hi;
    logic [1:0] mode;
    logic cs, gate, run, clk_tick, tick, go, go_h, ovf, ovf_h, t1_parked;
    logic [12:0] c13;
    assign mode = mode_select_reg[MS_STRIDE*i+:2]; // RULE16
    assign cs = mode_select_reg[MS_STRIDE*i+MS_CS];
    assign gate = mode_select_reg[MS_STRIDE*i+MS_GATE];
    assign t1_parked = (i == 1) && t0_split;
    assign clk_tick = timer_clock_control[CK_T0_SEL+i] ? 1'b1 : pre_tick; // RULE1
    // with timer 0 split, timer 1 is clock only and runs unless its own mode is split
    assign tick = (cs && !t1_parked) ? ev_fall[i] : clk_tick; // RULE2 RULE20 RULE21
    assign run = t1_parked ? 1'b1 : run_control_reg[RC_TR0+2*i] && (!gate || s2.gate[i]); // RULE15
    assign go = run && tick && !((i == 1) && mode == M_SPLIT);
    // split upper byte of timer 0 runs on tr1 from system or prescaled clock
    // and never from the event pin, as the split upper byte is a pure timer
    assign go_h = (i == 0) && mode == M_SPLIT && run_control_reg[RC_TR0+2] && clk_tick;
    assign c13 = {hi, lo[4:0]};
    assign ovf_h = go_h && hi == 8'hff;
    always_comb begin
      case (mode) // RULE17
        M_13BIT: ovf = go && c13 == 13'h1fff;
        M_16BIT: ovf = go && {hi, lo} == 16'hffff;
        default: ovf = go && lo == 8'hff;
      endcase
    end

    // mode 0 keeps the upper three bits of the low byte as software left them
    // count, then let a software byte write win over the count;
    // software must stop the timer to load a consistent byte pair
    always_ff @(posedge clk) begin
      if (!resetn) begin
        lo <= RST_BYTE;
        hi <= RST_BYTE;
      end else begin
        if (go) begin
          case (mode)
            M_13BIT: {hi, lo[4:0]} <= c13 + 13'h1; // RULE17
            M_16BIT: {hi, lo} <= {hi, lo} + 16'h1;
            M_RELOAD: lo <= ovf ? hi : lo + 8'h1;
            default: lo <= lo + 8'h1;
          endcase
        end
        if (go_h) begin
          hi <= hi + 8'h1;
        end
        if (req.wr && req.addr == (i == 0 ? A_T0LO : A_T1LO)) begin
          lo <= req.wdata; // RULE14
        end
        if (req.wr && req.addr == (i == 0 ? A_T0HI : A_T1HI)) begin
          hi <= req.wdata; // RULE14
        end
      end
    end
  end

  // a parked timer 1 loses its flag to the split upper byte of timer 0
  // timer 1 still counts in that case but cannot raise its own flag
  assign tf_set[0] = g_t01[0].ovf;
  assign tf_set[1] = t0_split ? g_t01[0].ovf_h : g_t01[1].ovf;

  // control registers; hardware flag set wins over a software clear
  // the low nibble of run control is plain storage for software
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_clock_control <= RST_BYTE;
      run_control_reg <= RST_BYTE;
      mode_select_reg <= RST_BYTE;
      ien <= RST_BYTE;
    end else begin
      if (req.wr && req.addr == A_TIMER_CLOCK_CONTROL) begin
        timer_clock_control <= req.wdata;
      end
      if (req.wr && req.addr == A_MODE) begin
        mode_select_reg <= req.wdata; // RULE16
      end
      if (req.wr && req.addr == A_IRQEN) begin
        ien <= req.wdata;
      end
      if (req.wr && req.addr == A_RUN) begin
        run_control_reg <= req.wdata;
      end
      if (tf_set[0]) begin
        run_control_reg[RC_TF0] <= 1'b1; // RULE15
      end
      if (tf_set[1]) begin
        run_control_reg[RC_TF0+2] <= 1'b1; // RULE15
      end
    end
  end

  // timers 2 and 3
  for (genvar j = 0; j < 2; j++) begin : g_t23
    logic [7:0] ctl;
    logic [15:0] rl, cnt;
    logic alt_tick, lo_tick, hi_tick, cap_ev, cap_tick;
    logic run, split, cap, go_l, go_h, ovf_l, ovf_h, ovf_w;
    // timer 2 alternate source is rtc/8, timer 3 is external oscillator/8
    // codes 00 and 11 both give system/12 so no code leaves the timer idle
    always_comb begin
      case (ctl[X_SEL+:2]) // RULE12 RULE13
        ALT_DIV12: alt_tick = div12_tick;
        ALT_SRC8: alt_tick = src8_tick[1-j];
        ALT_CMP: alt_tick = cmp_rise[j];
        default: alt_tick = div12_tick;
      endcase
    end
    assign lo_tick = timer_clock_control[CK_T23+2*j] ? 1'b1 : alt_tick; // RULE8 RULE10 RULE21
    assign hi_tick = timer_clock_control[CK_T23+2*j+1] ? 1'b1 : alt_tick; // RULE9 RULE11
    assign run = ctl[X_RUN];
    assign split = ctl[X_SPLIT];
    assign cap = ctl[X_CAP];
    // capture counts system clock or system/12 between measured edges
    // the capture event clears the count so each reading is one whole period
    // measured in the chosen reference ticks
    assign cap_tick = timer_clock_control[CK_T23+2*j] ? 1'b1 : div12_tick;
    assign cap_ev = (ctl[X_SEL+:2] == ALT_CMP) ? cmp_rise[j] : src8_tick[1-j]; // RULE19
    assign go_l = run && (cap ? cap_tick : lo_tick);
    assign go_h = run && !cap && split && hi_tick;
    assign ovf_l = go_l && split && !cap && cnt[7:0] == 8'hff;
    assign ovf_h = go_h && cnt[15:8] == 8'hff;
    assign ovf_w = go_l && !split && cnt == 16'hffff;

    always_ff @(posedge clk) begin
      if (!resetn) begin
        ctl <= RST_BYTE;
        rl <= '0;
        cnt <= '0;
      end else begin
        if (cap) begin
          if (go_l) begin
            cnt <= cnt + 16'h1;
          end
          if (run && cap_ev) begin
            rl <= cnt; // RULE19
            cnt <= '0;
          end
        end else if (split) begin
          if (go_l) begin
            cnt[7:0] <= ovf_l ? rl[7:0] : cnt[7:0] + 8'h1; // RULE18
          end
          if (go_h) begin
            cnt[15:8] <= ovf_h ? rl[15:8] : cnt[15:8] + 8'h1; // RULE18
          end
        end else if (go_l) begin
          cnt <= ovf_w ? rl : cnt + 16'h1; // RULE18
        end
        if (req.wr && hit23(req.addr, j, O_CTL)) begin
          ctl <= req.wdata;
        end
        if (req.wr && hit23(req.addr, j, O_RLL)) begin
          rl[7:0] <= req.wdata;
        end
        if (req.wr && hit23(req.addr, j, O_RLH)) begin
          rl[15:8] <= req.wdata;
        end
        if (req.wr && hit23(req.addr, j, O_CNL)) begin
          cnt[7:0] <= req.wdata;
        end
        if (req.wr && hit23(req.addr, j, O_CNH)) begin
          cnt[15:8] <= req.wdata;
        end
        // flags set after the write so an event in the clear cycle survives
        if (ovf_h || ovf_w || (cap && run && cap_ev)) begin
          ctl[X_HIF] <= 1'b1;
        end
        if (ovf_l) begin
          ctl[X_LOF] <= 1'b1;
        end
      end
    end
  end

  // read mux; unmapped addresses read as zero
  // timer 2/3 windows are decoded last so they override the plain map
  always_comb begin
    next_rd = '0;
    case (req.addr)
      A_TIMER_CLOCK_CONTROL: next_rd = timer_clock_control;
      A_RUN: next_rd = run_control_reg;
      A_MODE: next_rd = mode_select_reg;
      A_IRQEN: next_rd = ien;
      A_T0LO: next_rd = g_t01[0].lo;
      A_T1LO: next_rd = g_t01[1].lo;
      A_T0HI: next_rd = g_t01[0].hi;
      A_T1HI: next_rd = g_t01[1].hi;
      default: next_rd = '0;
    endcase
    for (int j = 0; j < 2; j++) begin
      if (hit23(req.addr, j, O_CTL)) begin
        next_rd = (j == 0) ? g_t23[0].ctl : g_t23[1].ctl;
      end
      if (hit23(req.addr, j, O_RLL)) begin
        next_rd = (j == 0) ? g_t23[0].rl[7:0] : g_t23[1].rl[7:0];
      end
      if (hit23(req.addr, j, O_RLH)) begin
        next_rd = (j == 0) ? g_t23[0].rl[15:8] : g_t23[1].rl[15:8];
      end
      if (hit23(req.addr, j, O_CNL)) begin
        next_rd = (j == 0) ? g_t23[0].cnt[7:0] : g_t23[1].cnt[7:0];
      end
      if (hit23(req.addr, j, O_CNH)) begin
        next_rd = (j == 0) ? g_t23[0].cnt[15:8] : g_t23[1].cnt[15:8];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  // so a stale answer never lingers on the bus between reads
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= req.rd ? next_rd : 8'h00;
    end
  end

  // interrupt requests: flag gated by its enable
  // flags are cleared only by software; the request follows one cycle later
  assign next_irq[0] = run_control_reg[RC_TF0] && ien[IE_T0]; // RULE15
  assign next_irq[1] = run_control_reg[RC_TF0+2] && ien[IE_T1]; // RULE15
  assign next_irq[2] = |g_t23[0].ctl[X_HIF:X_LOF] && ien[IE_T2];
  assign next_irq[3] = |g_t23[1].ctl[X_HIF:X_LOF] && ien[IE_T3];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= '0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule

/* File: verif/timer_clock_properties.sv */
// checker for the timer clock block: register port, interrupt gating, event counts
`timescale 1ns/1ps
module timer_clock_checker
  import timer_clock_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched ports
  input wire reg_req_s req,
  input wire logic [7:0] rd_data,
  input wire pins_s pins,
  input wire logic [3:0] irq
);
  logic [7:0] ck_sh, mode_sh, ie_sh, ev_cnt;
  logic tr0_sh;
  logic [2:0] sy;
  logic cnt_on;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow copies of the software-owned registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ck_sh <= 8'h00;
      mode_sh <= 8'h00;
      ie_sh <= 8'h00;
      tr0_sh <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == A_TIMER_CLOCK_CONTROL) ck_sh <= req.wdata;
      if (req.addr == A_MODE) mode_sh <= req.wdata;
      if (req.addr == A_IRQEN) ie_sh <= req.wdata;
      if (req.addr == A_RUN) tr0_sh <= req.wdata[RC_TR0];
    end
  end
  // two sync stages plus the edge stage, so edges land on the design's cycle
  always_ff @(posedge clk) begin
    if (!resetn) sy <= 3'h0;
    else sy <= {sy[1:0], pins.event_in[0]};
  end
  assign cnt_on = mode_sh[1:0] == M_16BIT && mode_sh[MS_CS] && !mode_sh[MS_GATE] && tr0_sh;
  // expected count, trusted only once software has loaded the low byte
  always_ff @(posedge clk) begin
    if (!resetn) ev_cnt <= 8'h00;
    else if (req.wr && req.addr == A_T0LO) ev_cnt <= req.wdata;
    else if (cnt_on && sy[2] && !sy[1]) ev_cnt <= ev_cnt + 8'h01;
  end
  a_rd_needs_read: assert property (rd_data != 8'h00 |-> $past(req.rd))
    else $error("read data without a read");
  a_reset_clears: assert property (!$past(resetn) |-> irq == 4'h0 && rd_data == 8'h00)
    else $error("outputs not clear after reset");
  a_unmapped_zero: assert property (req.rd && req.addr < A_RUN |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_timer_clock_control_readback:
    assert property (req.rd && req.addr == A_TIMER_CLOCK_CONTROL |=> rd_data == $past(ck_sh))
    else $error("clock control readback wrong");
  a_mode_readback:
    assert property (req.rd && req.addr == A_MODE |-> ##1 rd_data == $past(mode_sh))
    else $error("mode readback wrong");
  a_irqen_readback:
    assert property (req.rd && req.addr == A_IRQEN ##1 1'b1 |-> rd_data == $past(ie_sh))
    else $error("interrupt enable readback wrong");
  a_irq_enabled:
    assert property ((irq & ~$past({ie_sh[IE_T3], ie_sh[IE_T2], ie_sh[IE_T1], ie_sh[IE_T0]})) == 4'h0)
    else $error("interrupt raised while disabled");
  a_event_count:
    assert property (req.rd && req.addr == A_T0LO && cnt_on |=> rd_data == $past(ev_cnt))
    else $error("event count wrong");
endmodule
bind timer_clock_prescaler timer_clock_checker chk_u (.clk(clk), .resetn(resetn), .req(req),
  .rd_data(rd_data), .pins(pins), .irq(irq));

/* File: verif/pin_source.sv */
// model of the pins around the block: event pulses and an external clock
`timescale 1ns/1ps
module pin_source
  import timer_clock_pkg::*;
(
  // system clock, used only to time pin levels
  input wire logic clk,
  // pins toward the block
  output pins_s pins
);
  int seed = 42;
  // idle low so the synchronisers see no edge at reset release
  initial pins = '0;
  // n pulses on one event pin; each level lasts 2 to 5 clocks
  task automatic pulses(input int ch, input int n);
    int w;
    repeat (n) begin
      w = 2 + ($random(seed) & 3);
      @(posedge clk);
      pins.event_in[ch] <= 1'b1;
      repeat (w) @(posedge clk);
      pins.event_in[ch] <= 1'b0;
      repeat (w - 1) @(posedge clk);
    end
  endtask
  // clock toggling every 4 clocks, still outside the run; even toggle count ends low
  task automatic ext_run(input int cycles);
    repeat (cycles / 4) begin
      repeat (4) @(posedge clk);
      pins.ext <= ~pins.ext;
    end
  endtask
endmodule

/* File: verif/timer_clock_prescaler_bench.sv */
// self-checking bench for the timer clock selection and prescaler block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module timer_clock_prescaler_bench
  import timer_clock_pkg::*;
;
  typedef struct {
    string nm;
    int v;
    int tol;
  } note_s;
  logic clk;
  logic resetn;
  reg_req_s req;
  logic [7:0] rd_data;
  logic [7:0] exp_v;
  logic [3:0] irq;
  pins_s pins;
  logic rd_q = 1'b0;
  note_s notes[$];
  note_s nt;
  int errors = 0;
  int n_tests = 0;
  int ticks[5];
  timer_clock_prescaler dut_u (.clk(clk), .resetn(resetn), .req(req), .rd_data(rd_data),
    .pins(pins), .irq(irq));
  pin_source src_u (.clk(clk), .pins(pins));
  // one-cycle write strobe; an idle cycle separates calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // read strobe; the note goes first so the monitor always finds it
  task automatic rd(input logic [7:0] a, input int v, input int tol, input string nm);
    notes.push_back('{nm, v, tol});
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // answer stands only in the cycle after the strobe; tolerance covers divider phase
  always @(posedge clk) begin
    if (rd_q) begin
      nt = notes.pop_front();
      exp_v = 8'(nt.v);
      if (rd_data >= nt.v - nt.tol && rd_data <= nt.v + nt.tol) exp_v = rd_data;
      `CHK(nt.nm, exp_v, rd_data)
    end
    rd_q <= req.rd;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // the tests need under 6000 cycles; over five times that means a hang
  initial begin
    repeat (32000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    logic [7:0] ck;
    req = '0;
    resetn = 1'b0;
    ticks = '{482 / 12, 482 / 4, 482 / 48, 10, 482 % 256};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // reset value, readback and an unmapped place
    rd(A_TIMER_CLOCK_CONTROL, 0, 0, "timer_clock_control reset");
    wr(A_TIMER_CLOCK_CONTROL, 8'ha5);
    rd(A_TIMER_CLOCK_CONTROL, 8'ha5, 0, "timer_clock_control");
    rd(8'h80, 0, 0, "unmapped");
    $display("test registers done");
    // each of the five timer 0/1 timebases runs timers 0 and 1 for a fixed span, counted to within one tick
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 5; i++) begin
        ck = (i == 4) ? 8'h04 << t : 8'(i);
        wr(A_MODE, 8'h11);
        wr(A_TIMER_CLOCK_CONTROL, ck);
        wr(A_T0LO + 8'(t), 8'h00);
        wr(A_T0HI + 8'(t), 8'h00);
        wr(A_RUN, 8'h10 << (2 * t));
        if (i == 3) src_u.ext_run(640);
        else repeat (480) @(posedge clk);
        wr(A_RUN, 8'h00);
        rd(A_T0LO + 8'(t), ticks[i], 1, "prescaled count");
        rd(A_T0HI + 8'(t), (i == 4), 0, "high byte");
      end
    end
    $display("test prescale done");
    // falling edges count even with both clock select bits set to system clock
    for (int t = 0; t < 2; t++) begin
      wr(A_MODE, 8'h05 << (4 * t));
      wr(A_TIMER_CLOCK_CONTROL, 8'h0c);
      wr(A_T0LO + 8'(t), 8'h00);
      wr(A_RUN, 8'h10 << (2 * t));
      src_u.pulses(t, 25);
      repeat (4) @(posedge clk);
      rd(A_T0LO + 8'(t), 25, 0, "event count");
    end
    $display("test counter done");
    // overflow sets the flag; the request shows only while enabled
    wr(A_MODE, 8'h01);
    rd(A_MODE, 8'h01, 0, "mode");
    wr(A_TIMER_CLOCK_CONTROL, 8'h04);
    wr(A_T0HI, 8'hff);
    wr(A_T0LO, 8'hf0);
    wr(A_RUN, 8'h10);
    repeat (40) @(posedge clk);
    wr(A_RUN, 8'h20);
    rd(A_RUN, 8'h20, 0, "overflow flag");
    #1;
    `CHK("irq masked", 4'h0, irq)
    wr(A_IRQEN, 8'h02);
    rd(A_IRQEN, 8'h02, 0, "irq enable");
    #1;
    `CHK("irq raised", 4'h1, irq)
    wr(A_RUN, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 4'h0, irq)
    $display("test interrupt done");
    // timer 2 on the system clock wraps to its reload value and flags it
    wr(A_IRQEN, 8'h20);
    wr(A_T2BASE + O_CNL, 8'hf0);
    wr(A_T2BASE + O_CNH, 8'hff);
    // comparator source with idle pins gives no ticks until bit 4 is set
    wr(A_T2BASE + O_CTL, 8'h06);
    wr(A_TIMER_CLOCK_CONTROL, 8'h10);
    repeat (100) @(posedge clk);
    wr(A_TIMER_CLOCK_CONTROL, 8'h00);
    rd(A_T2BASE + O_CNL, 8'h56, 0, "timer2 count");
    #1;
    `CHK("timer2 irq", 4'h4, irq)
    $display("test timer2 done");
    give_verdict();
  end
endmodule
